/* File: rtl/nfcc_host.sv */
// Host controller driving an asynchronous NOR flash through its pins
// Operation
// RULE1 - Device array splits into uniform 128-KB erase blocks, count by density.
// RULE2 - Width select low gives 8-bit mode, byte lane bit picks byte.
// RULE3 - Width select high gives 16-bit mode, byte lane bit ignored.
// RULE4 - Device holds a 128-bit protection register for unique identification.
// RULE5 - Host writes only valid command sequences; device starts automation only then.
// RULE6 - Device sequencer runs erase, program and lock algorithms by itself.
// RULE7 - Block erase clears exactly one 128-KB block, others untouched.
// RULE8 - Erase may be suspended; other blocks stay readable and programmable.
// RULE9 - Program may be suspended; other blocks stay readable.
// RULE10 - Device write buffer holds 256 bytes or 256 words.
// RULE11 - Each block has a lock bit blocking erase and program.
// RULE12 - Host changes lock bits only through set and clear lock commands.
// RULE13 - Device status word reports completion of sequencer operations.
// RULE14 - In level mode status pin is low while sequencer is busy.
// RULE15 - In level mode status pin high when ready, suspended or in reset.
// RULE16 - Host may switch status pin to pulse mode signalling completion.
// RULE17 - Three chip enables decode together into device enabled or disabled.
// RULE18 - Disabled chip enables with reset input high give standby.
// RULE19 - Reset input low gives power-down and rejects every write.
// RULE20 - Host waits reset and wake delays after reset input rises.
// RULE21 - Reset input low resets sequencer and clears status word.
// RULE22 - Writes count only while chip enables decode to enabled.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module nfcc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [nfcc_pkg::ADDR_W-1:0] flash_addr_o,
    input wire logic [nfcc_pkg::DATA_W-1:0] flash_dq_i,
    output logic [nfcc_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe_o,
    output logic [2:0] chip_enable_group_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic width_sel_o,
    output logic reset_powerdown_n_o,
    input wire logic op_status_pin_i
);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    nfcc_pkg::nfcc_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] wake_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] ctrl_q;
    logic [nfcc_pkg::ADDR_W-1:0] addr_q;
    logic [nfcc_pkg::DATA_W-1:0] wdata_q;
    logic [nfcc_pkg::DATA_W-1:0] rdata_q;
    logic op_wr_q;
    logic done_q;
    logic refused_q;
    logic ready_prev_q;
    logic [nfcc_pkg::DATA_W-1:0] dq_sync;
    logic ready_sync;

    nfcc_sync #(.W(nfcc_pkg::DATA_W)) u_dq_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(flash_dq_i),
        .q_o(dq_sync)
    );
    nfcc_sync #(.W(1), .RST_ONE(1'b1)) u_sts_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(op_status_pin_i),
        .q_o(ready_sync)
    );

    // Bus decode: write commits at the edge where ack is seen
    wire wb_hit = wb_cyc_i & wb_stb_i;
    wire wr_en = wb_hit & wb_we_i & ack_q;
    wire busy = (state_q != nfcc_pkg::S_IDLE);
    wire awake = (wake_q == 8'(nfcc_pkg::WAKE_CYC));
    wire wr_ctrl = wr_en & (wb_adr_i == nfcc_pkg::REG_CTRL);
    wire wr_cmd = wr_en & (wb_adr_i == nfcc_pkg::REG_CMD) & wb_sel_i[0];
    wire wr_stat = wr_en & (wb_adr_i == nfcc_pkg::REG_STATUS) & wb_sel_i[0];
    wire go = wr_cmd & wb_dat_i[nfcc_pkg::CMD_GO]; // RULE5 RULE12
    // Pin traffic only after the wake delay and while not in power-down
    wire go_ok = go & ~busy & awake & ctrl_q[nfcc_pkg::CTRL_RP]; // RULE20 RULE19
    // Reset and width must not change under a running cycle
    wire refuse = (go & ~go_ok) | (wr_ctrl & busy);
    wire done_rise = ready_sync & ~ready_prev_q; // RULE14 RULE15 RULE16
    wire x16 = ctrl_q[nfcc_pkg::CTRL_X16];
    wire [2:0] ce_en = ctrl_q[nfcc_pkg::CTRL_CE_EN_LSB +: 3];
    wire [2:0] ce_off = ctrl_q[nfcc_pkg::CTRL_CE_OFF_LSB +: 3];
    wire [31:0] status_w = {16'h0000,
                            1'b0, addr_q[nfcc_pkg::ADDR_W-1:nfcc_pkg::BLOCK_LSB],
                            3'h0, refused_q, done_q, ready_sync, awake, busy}; // RULE1
    wire [31:0] rd_mux = (wb_adr_i == nfcc_pkg::REG_CTRL) ? ctrl_q :
                         (wb_adr_i == nfcc_pkg::REG_ADDR) ? {8'h00, addr_q} :
                         (wb_adr_i == nfcc_pkg::REG_WDATA) ? {16'h0000, wdata_q} :
                         (wb_adr_i == nfcc_pkg::REG_STATUS) ? status_w :
                         (wb_adr_i == nfcc_pkg::REG_RDATA) ? {16'h0000, rdata_q} : 32'h0;
    wire [31:0] ctrl_new = merge(ctrl_q, wb_dat_i, wb_sel_i);
    wire [31:0] addr_new = merge({8'h00, addr_q}, wb_dat_i, wb_sel_i);
    wire [31:0] wdata_new = merge({16'h0000, wdata_q}, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_hit & ~ack_q;
            if (wb_hit & ~ack_q) begin
                dat_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= nfcc_pkg::CTRL_RESET;
            addr_q <= '0;
            wdata_q <= '0;
        end else begin
            if (wr_ctrl & ~busy) begin
                ctrl_q <= ctrl_new;
            end
            if (wr_en & (wb_adr_i == nfcc_pkg::REG_ADDR) & ~busy) begin
                addr_q <= addr_new[nfcc_pkg::ADDR_W-1:0];
            end
            if (wr_en & (wb_adr_i == nfcc_pkg::REG_WDATA) & ~busy) begin
                wdata_q <= wdata_new[nfcc_pkg::DATA_W-1:0];
            end
        end
    end

    // Sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
            // Status pin idles high; matching it avoids a false completion
            ready_prev_q <= 1'b1;
        end else begin
            ready_prev_q <= ready_sync;
            done_q <= done_rise | (done_q & ~(wr_stat & wb_dat_i[nfcc_pkg::ST_DONE]));
            refused_q <= refuse | (refused_q & ~(wr_stat & wb_dat_i[nfcc_pkg::ST_REFUSED]));
        end
    end

    // Wake counter restarts whenever reset/power-down is asserted
    always_ff @(posedge clk_i) begin
        if (rst_i | ~ctrl_q[nfcc_pkg::CTRL_RP]) begin
            wake_q <= 8'h00;
        end else if (!awake) begin
            wake_q <= wake_q + 8'h01; // RULE20
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            nfcc_pkg::S_IDLE: begin
                if (go_ok) begin
                    state_d = nfcc_pkg::S_SETUP;
                end
            end
            nfcc_pkg::S_SETUP: begin
                state_d = nfcc_pkg::S_STROBE;
                cnt_d = op_wr_q ? 8'(nfcc_pkg::WE_CYC - 1) : 8'(nfcc_pkg::ACCESS_CYC - 1);
            end
            nfcc_pkg::S_STROBE: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    state_d = nfcc_pkg::S_HOLD;
                    cnt_d = 8'(nfcc_pkg::HOLD_CYC - 1);
                end
            end
            nfcc_pkg::S_HOLD: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    state_d = nfcc_pkg::S_IDLE;
                end
            end
            default: begin
                state_d = nfcc_pkg::S_IDLE;
            end
        endcase
    end

    wire read_end = (state_q == nfcc_pkg::S_STROBE) & ~op_wr_q & (cnt_q == 8'h00);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= nfcc_pkg::S_IDLE;
            cnt_q <= 8'h00;
            op_wr_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (go_ok) begin
                op_wr_q <= wb_dat_i[nfcc_pkg::CMD_WRITE];
            end
            if (read_end) begin
                // Byte mode returns the low lane only
                rdata_q <= x16 ? dq_sync : {8'h00, dq_sync[7:0]}; // RULE2 RULE3
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_addr_o <= '0;
            flash_dq_o <= '0;
        end else if (go_ok) begin
            // Lane bit forced low in x16, where the device ignores it
            flash_addr_o <= {addr_q[nfcc_pkg::ADDR_W-1:1], addr_q[0] & ~x16}; // RULE2 RULE3
            flash_dq_o <= x16 ? wdata_q : {8'h00, wdata_q[7:0]};
        end
    end

    // Chip enables hold the disabled pattern outside a cycle, so standby while reset input is high
    assign chip_enable_group_o = busy ? ce_en : ce_off; // RULE17 RULE18 RULE22
    assign flash_we_n_o = ~((state_q == nfcc_pkg::S_STROBE) & op_wr_q); // RULE22
    assign flash_oe_n_o = ~((state_q == nfcc_pkg::S_STROBE) & ~op_wr_q);
    assign flash_dq_oe_o = busy & op_wr_q;
    assign width_sel_o = x16;
    assign reset_powerdown_n_o = ctrl_q[nfcc_pkg::CTRL_RP]; // RULE19 RULE21
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_write_needs_rp: assert property (!flash_we_n_o |-> reset_powerdown_n_o) // RULE19
        else $error("write strobe during power-down");
    chk_write_ce_enabled: assert property (!flash_we_n_o |-> chip_enable_group_o == ce_en) // RULE22
        else $error("write strobe with chip enables not at enable pattern");
    chk_access_after_wake: assert property ($fell(flash_oe_n_o) || $fell(flash_we_n_o)
        |-> wake_q == 8'(nfcc_pkg::WAKE_CYC)) // RULE20
        else $error("pin access before wake delay expired");
    chk_x16_lane_low: assert property (busy && width_sel_o |-> !flash_addr_o[0]) // RULE3
        else $error("byte lane bit driven in x16 mode");
    chk_we_pulse_len: assert property ($fell(flash_we_n_o)
        |-> !flash_we_n_o[*5] ##1 flash_we_n_o) // RULE22
        else $error("write strobe width wrong");
    chk_no_contention: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
        else $error("host drives data while output enable low");
    chk_rp_low_sleeps: assert property (!reset_powerdown_n_o |=> wake_q == 8'h00) // RULE20
        else $error("wake counter runs in power-down");
    chk_done_sticky: assert property (done_rise |=> done_q) // RULE16
        else $error("completion edge not captured");
    chk_refused_go: assert property (go && busy |=> refused_q && state_q != nfcc_pkg::S_SETUP)
        else $error("command accepted while busy");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule
`default_nettype wire

/* File: rtl/nfcc_pkg.sv */
// Constants, register map and state codes of the NOR flash host controller
package nfcc_pkg;
    // Clock and pin timing, in ns as documented or chosen, then in cycles
    localparam int CLK_NS = 4;
    localparam int RESET_DLY_NS = 100;
    localparam int WAKE_DLY_NS = 100;
    localparam int ACCESS_NS = 80;
    localparam int WE_PULSE_NS = 20;
    localparam int HOLD_NS = 12;
    localparam int SYNC_CYC = 2;
    localparam int RESET_DLY_CYC = (RESET_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_DLY_CYC = (WAKE_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (RESET_DLY_CYC > WAKE_DLY_CYC) ? RESET_DLY_CYC : WAKE_DLY_CYC;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

    // Array organisation
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BLOCK_LSB = 17;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;

    // Control fields and reset value
    localparam int CTRL_X16 = 0;
    localparam int CTRL_RP = 1;
    localparam int CTRL_CE_EN_LSB = 4;
    localparam int CTRL_CE_OFF_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0700;

    // Command fields
    localparam int CMD_GO = 0;
    localparam int CMD_WRITE = 1;

    // Status fields
    localparam int ST_BUSY = 0;
    localparam int ST_AWAKE = 1;
    localparam int ST_READY = 2;
    localparam int ST_DONE = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_BLOCK_LSB = 8;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SETUP = 4'b0010,
        S_STROBE = 4'b0100,
        S_HOLD = 4'b1000
    } nfcc_state_t;
endpackage

/* File: rtl/nfcc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module nfcc_sync #(
    parameter int W = 1,
    parameter logic RST_ONE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Reset to the pin's idle level, so no false edge follows reset
            meta_q <= {W{RST_ONE}};
            sync_q <= {W{RST_ONE}};
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

/* File: testbench/nfcc_flash_model.sv */
// Behavioural model of the NOR flash device at the controller's pins
`timescale 1ns/1ns
`default_nettype none
module nfcc_flash_model #(
    parameter logic [2:0] CE_ON = 3'b000,
    parameter int WAKE_NS = 100,
    parameter int BUSY_NS = 80,
    parameter logic [6:0] LOCK_BLK = 7'h7e
) (
    input wire logic [23:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    input wire logic [2:0] ce_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic width_sel_i,
    input wire logic rp_n_i,
    output logic sts_o
);
    logic [15:0] mem [0:255];
    logic [15:0] last;
    time t_up;
    wire sel_on = (ce_i == CE_ON);
    wire [7:0] widx = addr_i[8:1];
    // One block is held locked so a refused write can be seen
    wire blk_open = (addr_i[23:17] != LOCK_BLK);
    initial begin
        t_up = 0;
        last = 16'h0000;
        sts_o = 1'b1;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
    end
    always @(posedge rp_n_i) t_up = $time;
    // Reset clears the sequencer, so the pin reports ready
    always @(negedge rp_n_i) sts_o <= 1'b1;
    // Sequencer runs the whole operation by itself; no command decode kept
    always @(posedge we_n_i) begin
        if (sel_on && rp_n_i && blk_open && ($time - t_up >= WAKE_NS)) begin
            if (width_sel_i) begin
                mem[widx] = dq_i;
            end else if (addr_i[0]) begin
                mem[widx][15:8] = dq_i[7:0];
            end else begin
                mem[widx][7:0] = dq_i[7:0];
            end
            sts_o = 1'b0;
            sts_o <= #BUSY_NS 1'b1;
        end
    end
    // Released bus shows the inverse of the last value, never a stale copy
    always @(oe_n_i or ce_i or addr_i or rp_n_i or width_sel_i) begin
        if (!oe_n_i && sel_on && rp_n_i) begin
            dq_o = width_sel_i ? mem[widx]
                : {~last[15:8], addr_i[0] ? mem[widx][15:8] : mem[widx][7:0]};
            last = dq_o;
        end else begin
            dq_o = ~last;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/test_nfcc_host.sv */
// Testbench of the NOR flash host controller with a device model
`timescale 1ns/1ns
`default_nettype none
module test_nfcc_host;
    typedef struct packed {
        logic [31:0] wctl;
        logic [23:0] wa;
        logic [15:0] wd;
        logic [31:0] rctl;
        logic [23:0] ra;
        logic [15:0] ex;
    } nfcc_row_t;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] r;
    wire [31:0] rdat;
    wire ack;
    wire [23:0] faddr;
    wire [15:0] hdq, ddq;
    wire hoe, oe_n, we_n, wsel, rp_n, sts;
    wire [2:0] ce;
    wire [15:0] bus_dq = hoe ? hdq : ddq;
    int fails = 0;
    int comparisons = 0;
    nfcc_row_t rows [5];
    always #2 clk_i = ~clk_i;
    nfcc_host u_nfcc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .flash_addr_o(faddr), .flash_dq_i(bus_dq), .flash_dq_o(hdq),
        .flash_dq_oe_o(hoe), .chip_enable_group_o(ce), .flash_oe_n_o(oe_n),
        .flash_we_n_o(we_n), .width_sel_o(wsel), .reset_powerdown_n_o(rp_n),
        .op_status_pin_i(sts));
    nfcc_flash_model u_nfcc_flash_model (.addr_i(faddr), .dq_i(bus_dq), .dq_o(ddq),
        .ce_i(ce), .oe_n_i(oe_n), .we_n_i(we_n), .width_sel_i(wsel), .rp_n_i(rp_n),
        .sts_o(sts));
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask
    task report_and_stop;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(nfcc_pkg::REG_STATUS, r);
            n++;
        end while (r[b] !== v && n < 100);
        if (n >= 100) fails++;
    endtask
    task op(input logic [31:0] ctl, input logic [23:0] a, input logic [15:0] d,
            input logic w);
        wr(nfcc_pkg::REG_CTRL, ctl);
        wr(nfcc_pkg::REG_ADDR, {8'h00, a});
        if (w) wr(nfcc_pkg::REG_WDATA, {16'h0, d});
        wr(nfcc_pkg::REG_CMD, w ? 32'h3 : 32'h1);
        wait_bit(nfcc_pkg::ST_BUSY, 1'b0);
    endtask
    initial begin
        #100000;
        fails++;
        report_and_stop;
    end
    initial begin
        rows[0] = '{32'h703, 24'h000010, 16'h1234, 32'h703, 24'h000010, 16'h1234};
        rows[1] = '{32'h703, 24'h000021, 16'habcd, 32'h703, 24'h000020, 16'habcd};
        rows[2] = '{32'h702, 24'h000030, 16'h0055, 32'h702, 24'h000030, 16'h0055};
        rows[3] = '{32'h702, 24'h000031, 16'h00aa, 32'h703, 24'h000030, 16'haa55};
        rows[4] = '{32'h703, 24'hfe0002, 16'h5a5a, 32'h703, 24'hfe0002, 16'h5a5a};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("rp_n", 32'h0, {31'h0, rp_n});
        check("ce", 32'h7, {29'h0, ce});
        rd(nfcc_pkg::REG_CTRL, r);
        check("ctrl", 32'h700, r);
        rd(8'h20, r);
        check("unmapped", 32'h0, r);
        // Go straight after power-up must not reach the device yet
        wr(nfcc_pkg::REG_CTRL, 32'h703);
        wr(nfcc_pkg::REG_CMD, 32'h1);
        rd(nfcc_pkg::REG_STATUS, r);
        check("early go", 32'h1, {31'h0, r[4]});
        wr(nfcc_pkg::REG_STATUS, 32'h18);
        wait_bit(nfcc_pkg::ST_AWAKE, 1'b1);
        foreach (rows[i]) begin
            op(rows[i].wctl, rows[i].wa, rows[i].wd, 1'b1);
            op(rows[i].rctl, rows[i].ra, 16'h0, 1'b0);
            rd(nfcc_pkg::REG_RDATA, r);
            check("rdata", {16'h0, rows[i].ex}, r);
            rd(nfcc_pkg::REG_STATUS, r);
            check("block", {25'h0, rows[i].ra[23:17]}, {25'h0, r[14:8]});
        end
        // Write with the device deselected is lost
        op(32'h713, 24'h000010, 16'h9999, 1'b1);
        op(32'h703, 24'h000010, 16'h0, 1'b0);
        rd(nfcc_pkg::REG_RDATA, r);
        check("deselected", 32'h1234, r);
        // Write into the device's locked block must not land
        op(32'h703, 24'hfc0004, 16'h7777, 1'b1);
        op(32'h703, 24'hfc0004, 16'h0, 1'b0);
        rd(nfcc_pkg::REG_RDATA, r);
        check("locked", 32'h0, r);
        wr(nfcc_pkg::REG_CMD, 32'h1);
        wr(nfcc_pkg::REG_CMD, 32'h1);
        rd(nfcc_pkg::REG_STATUS, r);
        check("busy go", 32'h1, {31'h0, r[4]});
        wait_bit(nfcc_pkg::ST_BUSY, 1'b0);
        repeat (40) @(posedge clk_i);
        wr(nfcc_pkg::REG_STATUS, 32'h18);
        op(32'h703, 24'h000040, 16'h0f0f, 1'b1);
        rd(nfcc_pkg::REG_STATUS, r);
        check("pin busy", 32'h0, {31'h0, r[2]});
        repeat (30) @(posedge clk_i);
        rd(nfcc_pkg::REG_STATUS, r);
        check("pin ready", 32'h3, {30'h0, r[3:2]});
        wr(nfcc_pkg::REG_CTRL, 32'h701);
        wr(nfcc_pkg::REG_CMD, 32'h3);
        rd(nfcc_pkg::REG_STATUS, r);
        check("pd refused", 32'h1, {31'h0, r[4]});
        check("pd pin", 32'h0, {31'h0, rp_n});
        // Reset while idle in power-down leaves the pins in power-down and standby
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("reset pins", 32'h6, {28'h0, ack, oe_n, we_n, rp_n});
        check("reset ce", 32'h7, {29'h0, ce});
        repeat (8) @(posedge clk_i);
        rd(nfcc_pkg::REG_STATUS, r);
        check("false done", 32'h0, {31'h0, r[3]});
        report_and_stop;
    end
endmodule
`default_nettype wire
